// ==== design/tlp_decide.sv ====
// Decides completion and credit handling for one received TLP header.
`timescale 1ns/1ps
`include "ur_host_defines.svh"
module tlp_decide (
   input  wire logic [7:0]           fmt_type,
   input  wire logic [7:0]           msg_code,
   input  wire logic [6:0]           bar_hit,
   input  wire logic                 us_flag,
   input  wire ur_host_pkg::ctrl_t   ctrl,
   output ur_host_pkg::decision_t    decision
);

   logic hit_io;
   logic hit_mem;

   assign hit_io  = |(bar_hit & ctrl.bar_io);
   assign hit_mem = |(bar_hit & ~ctrl.bar_io);

   always_comb begin
      decision         = '0;
      decision.flagged = us_flag;
      case (fmt_type)
         // Memory read: forwarded on a memory window hit with memory support on, otherwise UR.
         `FT_MRD32, `FT_MRD64: begin
            decision.rel_nph = 1'b1;
            if (hit_mem && ctrl.mem_ok) begin
               decision.to_app = 1'b1;
            end else begin
               decision.send_cpl = 1'b1;
               decision.ur       = 1'b1;
            end
         end
         `FT_MRDLK32, `FT_MRDLK64: begin
            decision.rel_nph  = 1'b1;
            decision.send_cpl = 1'b1;
            decision.ur       = 1'b1;
         end
         `FT_IORD, `FT_IOWR: begin
            decision.rel_nph = 1'b1;
            if (hit_io && ctrl.io_ok) begin
               decision.to_app = 1'b1;
            end else begin
               decision.send_cpl = 1'b1;
               decision.ur       = 1'b1;
            end
         end
         `FT_MWR32, `FT_MWR64: begin
            decision.rel_ph = 1'b1;
            decision.rel_pd = 1'b1;
            decision.to_app = hit_mem && ctrl.mem_ok;
         end
         `FT_CFGRD0, `FT_CFGWR0: begin
            decision.rel_nph = !ctrl.term_cfg;
            decision.to_app  = !ctrl.term_cfg;
         end
         `FT_CPLLK, `FT_CPLDLK: begin
            decision.rel_nph = 1'b0;
         end
         default: begin
            if (fmt_type[7:3] == `FT_MSG_HI || fmt_type[7:3] == `FT_MSGD_HI) begin
               decision.rel_ph = 1'b1;
               decision.rel_pd = (fmt_type[7:3] == `FT_MSGD_HI);
               if (msg_code == `MSG_VDM0 || msg_code == `MSG_VDM1) begin
                  decision.send_cpl = 1'b1;
                  decision.ur       = 1'b1;
               end
            end
         end
      endcase
   end

endmodule

// ==== design/ur_host.sv ====
// Host controller that terminates unsupported requests and drives the endpoint side pins.
`timescale 1ns/1ps
`include "ur_host_defines.svh"
module ur_host #(
   parameter int MSI_VECTORS = 8
) (
   input  wire logic                 clk,
   input  wire logic                 nrst,
   input  wire logic                 wb_cyc_i,
   input  wire logic                 wb_stb_i,
   input  wire logic                 wb_we_i,
   input  wire logic [7:0]           wb_adr_i,
   input  wire logic [3:0]           wb_sel_i,
   input  wire logic [31:0]          wb_dat_i,
   output      logic [31:0]          wb_dat_o,
   output      logic                 wb_ack_o,
   input  wire logic                 receive_tlp_start,
   input  wire logic                 receive_tlp_end,
   input  wire logic [63:0]          receive_data,
   input  wire logic [6:0]           receive_bar_hit,
   input  wire logic                 unsupported_request_flag,
   input  wire logic                 receive_ecrc_error,
   input  wire logic                 receive_malformed,
   input  wire logic                 msi_enable_in,
   input  wire logic [2:0]           multi_message_enable_out,
   input  wire logic [1:0]           power_state_out,
   input  wire logic                 pme_status_in,
   input  wire logic                 pme_enable_in,
   input  wire logic [3:0]           command_bits_in,
   input  wire logic [15:0]          device_control_in,
   input  wire logic [15:0]          link_control_in,
   output      logic [7:0]           msi_request,
   output      logic                 nonposted_header_done,
   output      logic                 posted_header_done,
   output      logic                 posted_data_done,
   output      logic [7:0]           posted_data_count,
   output      logic                 completion_timeout_out,
   output      logic                 completer_abort_nonposted_in,
   output      logic                 completer_abort_posted,
   output      logic                 unexpected_completion,
   output      logic [127:0]         errored_tlp_header,
   output      logic                 cpl_req_valid,
   input  wire logic                 cpl_req_ready,
   output      ur_host_pkg::cpl_req_t cpl_req,
   output      logic                 app_tlp_valid,
   output      logic [63:0]          app_tlp_header
);

   if (MSI_VECTORS < 1 || MSI_VECTORS > 8) begin : g_bad_vectors
      $error("MSI_VECTORS must lie between 1 and 8");
   end

   typedef struct packed {
      ur_host_pkg::fsm_t      fsm;
      logic [63:0]            hdr;
      ur_host_pkg::decision_t dec;
      ur_host_pkg::ctrl_t     ctrl;
      logic                   ack;
      logic [31:0]            rdata;
      logic [7:0]             msi;
      logic [3:0]             aer;
      logic [15:0]            ur_cnt;
      logic [15:0]            flag_cnt;
      logic [15:0]            drop_cnt;
      logic                   app;
      logic                   nph;
      logic                   ph;
      logic                   pd;
      logic [7:0]             pd_num;
      logic                   cpl_valid;
      ur_host_pkg::cpl_req_t  cpl;
   } host_state_t;

   localparam logic [8:0] VEC_ONE = 9'h001;
   localparam logic [7:0] VEC_CAP = 8'(( VEC_ONE << MSI_VECTORS) - VEC_ONE);

   host_state_t            state_ff;
   host_state_t            nxt_state;
   ur_host_pkg::decision_t new_dec;
   logic                   bus_req;
   logic                   bus_wr;
   logic                   rx_error;
   logic [31:0]            lane_mask;
   logic [31:0]            rd_mux;
   logic [7:0]             vec_mask;
   logic [7:0]             credit_num;

   tlp_decide u_decide (
      .fmt_type (receive_data[`HDR_FT_MSB:`HDR_FT_LSB]),
      .msg_code (receive_data[`HDR_CODE_MSB:`HDR_CODE_LSB]),
      .bar_hit  (receive_bar_hit),
      .us_flag  (unsupported_request_flag),
      .ctrl     (state_ff.ctrl),
      .decision (new_dec)
   );

   assign bus_req   = wb_cyc_i && wb_stb_i && !state_ff.ack;
   assign bus_wr    = wb_cyc_i && wb_stb_i && wb_we_i && state_ff.ack;
   assign rx_error  = receive_ecrc_error || receive_malformed;
   assign lane_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

   // One data credit per four dwords, rounded up.
   assign credit_num = state_ff.hdr[`HDR_LEN_MSB:`HDR_LEN_QLSB]
                       + {7'h00, |state_ff.hdr[`HDR_LEN_QLSB-1:`HDR_LEN_LSB]};

   // Only vectors granted by the multiple-message enable may be raised.
   always_comb begin
      case (multi_message_enable_out)
         3'h0:    vec_mask = 8'h01 & VEC_CAP;
         3'h1:    vec_mask = 8'h03 & VEC_CAP;
         3'h2:    vec_mask = 8'h0F & VEC_CAP;
         default: vec_mask = VEC_CAP;
      endcase
   end

   always_comb begin
      case (wb_adr_i)
         `OFS_CTRL:       rd_mux = {22'h000000, state_ff.ctrl};
         `OFS_STATUS:     rd_mux = {20'h00000, pme_enable_in, pme_status_in, command_bits_in,
                                    power_state_out, multi_message_enable_out, msi_enable_in};
         `OFS_LINK:       rd_mux = {link_control_in, device_control_in};
         `OFS_UR_COUNT:   rd_mux = {state_ff.flag_cnt, state_ff.ur_cnt};
         `OFS_DROP_COUNT: rd_mux = {16'h0000, state_ff.drop_cnt};
         `OFS_HDR_LO:     rd_mux = state_ff.hdr[31:0];
         `OFS_HDR_HI:     rd_mux = state_ff.hdr[63:32];
         default:         rd_mux = 32'h00000000;
      endcase
   end

   always_comb begin
      nxt_state     = state_ff;
      nxt_state.ack = bus_req;
      nxt_state.msi = 8'h00;
      nxt_state.aer = 4'h0;
      nxt_state.app = 1'b0;
      nxt_state.nph = 1'b0;
      nxt_state.ph  = 1'b0;
      nxt_state.pd  = 1'b0;
      if (bus_req) begin
         nxt_state.rdata = rd_mux;
      end
      // Writes commit on the edge at which the master sees the acknowledge.
      if (bus_wr) begin
         case (wb_adr_i)
            `OFS_CTRL: begin
               nxt_state.ctrl = `CTRL_W'(({22'h000000, state_ff.ctrl} & ~lane_mask)
                                         | (wb_dat_i & lane_mask));
            end
            `OFS_MSI_ISSUE: begin
               // One-cycle high gives a rising edge per vector.
               if (wb_sel_i[0]) begin
                  nxt_state.msi = wb_dat_i[7:0] & vec_mask & {8{msi_enable_in}};
               end
            end
            `OFS_AER_REPORT: begin
               if (wb_sel_i[0]) begin
                  nxt_state.aer = wb_dat_i[3:0];
               end
            end
            default: begin
               nxt_state.aer = 4'h0;
            end
         endcase
      end
      case (state_ff.fsm)
         ur_host_pkg::ST_IDLE: begin
            // Device flag sampled with the start beat.
            if (receive_tlp_start) begin
               nxt_state.hdr = receive_data;
               nxt_state.dec = new_dec;
               if (new_dec.flagged) begin
                  nxt_state.flag_cnt = state_ff.flag_cnt + 16'h0001;
               end
               if (receive_tlp_end && rx_error) begin
                  nxt_state.drop_cnt = state_ff.drop_cnt + 16'h0001;
               end else if (receive_tlp_end) begin
                  nxt_state.fsm = ur_host_pkg::ST_RELEASE;
                  nxt_state.nph = new_dec.rel_nph;
                  nxt_state.ph  = new_dec.rel_ph;
                  nxt_state.pd  = new_dec.rel_pd;
                  nxt_state.app = new_dec.to_app;
               end else begin
                  nxt_state.fsm = ur_host_pkg::ST_BODY;
               end
            end
         end
         ur_host_pkg::ST_BODY: begin
            // Errored TLPs are dropped without credit or completion.
            if (receive_tlp_end && rx_error) begin
               nxt_state.fsm      = ur_host_pkg::ST_IDLE;
               nxt_state.drop_cnt = state_ff.drop_cnt + 16'h0001;
            end else if (receive_tlp_end) begin
               nxt_state.fsm = ur_host_pkg::ST_RELEASE;
               nxt_state.nph = state_ff.dec.rel_nph;
               nxt_state.ph  = state_ff.dec.rel_ph;
               nxt_state.pd  = state_ff.dec.rel_pd;
               nxt_state.app = state_ff.dec.to_app;
            end
         end
         ur_host_pkg::ST_RELEASE: begin
            nxt_state.pd_num = credit_num;
            if (state_ff.dec.send_cpl) begin
               nxt_state.fsm           = ur_host_pkg::ST_ANSWER;
               nxt_state.cpl_valid     = 1'b1;
               nxt_state.cpl.status    = state_ff.dec.ur ? `CPL_UR : `CPL_SC;
               nxt_state.cpl.requester = state_ff.hdr[`HDR_REQ_MSB:`HDR_REQ_LSB];
               nxt_state.cpl.tag       = state_ff.hdr[`HDR_TAG_MSB:`HDR_TAG_LSB];
            end else begin
               nxt_state.fsm = ur_host_pkg::ST_IDLE;
            end
         end
         ur_host_pkg::ST_ANSWER: begin
            if (cpl_req_ready) begin
               nxt_state.fsm       = ur_host_pkg::ST_IDLE;
               nxt_state.cpl_valid = 1'b0;
               nxt_state.ur_cnt    = state_ff.ur_cnt + 16'h0001;
            end
         end
         default: begin
            nxt_state.fsm = ur_host_pkg::ST_IDLE;
         end
      endcase
      // A start while the previous TLP is still in body, release or answer cannot be served.
      if (receive_tlp_start && state_ff.fsm != ur_host_pkg::ST_IDLE) begin
         nxt_state.drop_cnt = state_ff.drop_cnt + 16'h0001;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_ff           <= '0;
         state_ff.fsm       <= ur_host_pkg::ST_IDLE;
         state_ff.ctrl      <= `CTRL_RESET;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Data credit count comes straight from the header during the pulse and is held in pd_num after it.
   assign posted_data_count            = (state_ff.fsm == ur_host_pkg::ST_RELEASE)
                                         ? credit_num : state_ff.pd_num;
   assign wb_dat_o                     = state_ff.rdata;
   assign wb_ack_o                     = state_ff.ack;
   assign msi_request                  = state_ff.msi;
   assign nonposted_header_done        = state_ff.nph;
   assign posted_header_done           = state_ff.ph;
   assign posted_data_done             = state_ff.pd;
   assign completion_timeout_out       = state_ff.aer[`AER_TOUT_BIT];
   assign completer_abort_nonposted_in = state_ff.aer[`AER_ABNP_BIT];
   assign completer_abort_posted       = state_ff.aer[`AER_ABP_BIT];
   assign unexpected_completion        = state_ff.aer[`AER_UNEXP_BIT];
   assign errored_tlp_header           = {state_ff.hdr, 64'h0000000000000000};
   assign cpl_req_valid                = state_ff.cpl_valid;
   assign cpl_req                      = state_ff.cpl;
   assign app_tlp_valid                = state_ff.app;
   assign app_tlp_header               = state_ff.hdr;

   logic       in_release;
   logic [7:0] held_ft;
   logic [7:0] held_code;
   logic       held_nobar;

   assign in_release = (state_ff.fsm == ur_host_pkg::ST_RELEASE);
   assign held_ft    = state_ff.hdr[`HDR_FT_MSB:`HDR_FT_LSB];
   assign held_code  = state_ff.hdr[`HDR_CODE_MSB:`HDR_CODE_LSB];

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         held_nobar <= 1'b0;
      end else if (receive_tlp_start && state_ff.fsm == ur_host_pkg::ST_IDLE) begin
         held_nobar <= (receive_bar_hit == 7'h00);
      end
   end

   sequence ur_answer_s;
      cpl_req_valid && cpl_req.status == `CPL_UR;
   endsequence

   sequence no_answer_s;
      !cpl_req_valid;
   endsequence

   property release_then_p(cond, credit, answer_seq);
      @(posedge clk) disable iff (!nrst)
         (in_release && cond) |-> credit ##1 answer_seq;
   endproperty

   lockrd_ur_a: assert property (release_then_p(
      held_ft == `FT_MRDLK32 || held_ft == `FT_MRDLK64, nonposted_header_done, ur_answer_s))
      else $error("locked read not answered with UR");

   lockcpl_quiet_a: assert property (release_then_p(
      held_ft == `FT_CPLLK || held_ft == `FT_CPLDLK,
      !nonposted_header_done && !posted_header_done, no_answer_s))
      else $error("locked completion was answered or credited");

   vendor_msg_ur_a: assert property (release_then_p(
      held_ft[7:3] == `FT_MSG_HI && (held_code == `MSG_VDM0 || held_code == `MSG_VDM1),
      posted_header_done, ur_answer_s))
      else $error("vendor message not answered with UR");

   cfg_term_quiet_a: assert property (release_then_p(
      (held_ft == `FT_CFGRD0 || held_ft == `FT_CFGWR0) && state_ff.ctrl.term_cfg,
      !nonposted_header_done, no_answer_s))
      else $error("terminated configuration request was handled");

   nobar_read_ur_a: assert property (release_then_p(
      (held_ft == `FT_MRD32 || held_ft == `FT_MRD64) && held_nobar,
      nonposted_header_done, ur_answer_s))
      else $error("read outside every window not answered with UR");

   mwr_posted_a: assert property (release_then_p(
      held_ft == `FT_MWR32 || held_ft == `FT_MWR64,
      posted_header_done && posted_data_done, no_answer_s))
      else $error("posted write credit or completion wrong");

   nph_one_cycle_a: assert property (@(posedge clk) disable iff (!nrst)
      $rose(nonposted_header_done) |=> !nonposted_header_done)
      else $error("non-posted credit pulse longer than one cycle");

   cpl_hold_a: assert property (@(posedge clk) disable iff (!nrst)
      (cpl_req_valid && !cpl_req_ready) |=> cpl_req_valid && $stable(cpl_req))
      else $error("completion request dropped before ready");

   msi_edge_a: assert property (@(posedge clk) disable iff (!nrst)
      (msi_request != 8'h00) |=> msi_request == 8'h00)
      else $error("interrupt request bit held high");

   aer_pulse_a: assert property (@(posedge clk) disable iff (!nrst)
      (bus_wr && wb_adr_i == `OFS_AER_REPORT && wb_sel_i[0])
      |=> completion_timeout_out == $past(wb_dat_i[`AER_TOUT_BIT]) ##1 !completion_timeout_out)
      else $error("error report pulse wrong");

endmodule

// ==== design/ur_host_defines.svh ====
// Offsets, field positions, reset values and TLP codes of the unsupported-request host.
`ifndef UR_HOST_DEFINES_SVH
`define UR_HOST_DEFINES_SVH

// Byte offsets of the host's own registers on the Wishbone slave.
`define OFS_CTRL        8'h00
`define OFS_MSI_ISSUE   8'h04
`define OFS_AER_REPORT  8'h08
`define OFS_STATUS      8'h0C
`define OFS_LINK        8'h10
`define OFS_UR_COUNT    8'h14
`define OFS_DROP_COUNT  8'h18
`define OFS_HDR_LO      8'h1C
`define OFS_HDR_HI      8'h20

// Control register: terminate-configuration, memory support, I/O support, I/O window map.
`define CTRL_W          10
`define CTRL_RESET      10'h001
`define CTRL_TERM_BIT   0
`define CTRL_MEM_BIT    1
`define CTRL_IO_BIT     2
`define CTRL_BARIO_LSB  3

// Report register bit positions.
`define AER_TOUT_BIT    0
`define AER_ABNP_BIT    1
`define AER_ABP_BIT     2
`define AER_UNEXP_BIT   3

// Device-side map, kept for software reference only.
`define DEV_MSI_DWORD   12'h070
`define DEV_MSI_EN_BIT  16

// Header fields of the first receive beat.
`define HDR_FT_MSB      63
`define HDR_FT_LSB      56
`define HDR_LEN_MSB     41
`define HDR_LEN_QLSB    34
`define HDR_LEN_LSB     32
`define HDR_REQ_MSB     31
`define HDR_REQ_LSB     16
`define HDR_TAG_MSB     15
`define HDR_TAG_LSB     8
`define HDR_CODE_MSB    7
`define HDR_CODE_LSB    0

// Format and type codes.
`define FT_MRD32        8'h00
`define FT_MRD64        8'h20
`define FT_MRDLK32      8'h01
`define FT_MRDLK64      8'h21
`define FT_IORD         8'h02
`define FT_IOWR         8'h42
`define FT_CFGRD0       8'h04
`define FT_CFGWR0       8'h44
`define FT_MWR32        8'h40
`define FT_MWR64        8'h60
`define FT_CPLLK        8'h0B
`define FT_CPLDLK       8'h4B
`define FT_MSG_HI       5'h06
`define FT_MSGD_HI      5'h0E
`define MSG_VDM0        8'h7E
`define MSG_VDM1        8'h7F

// Completion status codes.
`define CPL_SC          3'h0
`define CPL_UR          3'h1

`endif

// ==== design/ur_host_pkg.sv ====
// Types shared by the unsupported-request host controller.
`include "ur_host_defines.svh"
package ur_host_pkg;

   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_BODY    = 2'b01,
      ST_RELEASE = 2'b11,
      ST_ANSWER  = 2'b10
   } fsm_t;

   typedef struct packed {
      logic [6:0] bar_io;
      logic       io_ok;
      logic       mem_ok;
      logic       term_cfg;
   } ctrl_t;

   typedef struct packed {
      logic send_cpl;
      logic ur;
      logic rel_ph;
      logic rel_pd;
      logic rel_nph;
      logic to_app;
      logic flagged;
   } decision_t;

   typedef struct packed {
      logic [2:0]  status;
      logic [15:0] requester;
      logic [7:0]  tag;
   } cpl_req_t;

endpackage

// ==== test/device_model.sv ====
// Device side model: presents received TLPs and raises the unsupported flag.
`timescale 1ns/1ps
`include "ur_host_defines.svh"
module device_model (
   input  wire logic        clk,
   output      logic        receive_tlp_start,
   output      logic        receive_tlp_end,
   output      logic [63:0] receive_data,
   output      logic [6:0]  receive_bar_hit,
   output      logic        unsupported_request_flag
);
   initial {receive_tlp_start, receive_tlp_end, unsupported_request_flag, receive_data,
            receive_bar_hit} = '0;
   // One-beat TLP: e holds {type, message code, window hits, expectation}.
   task automatic send(input logic [26:0] e);
      @(posedge clk);
      {receive_tlp_start, receive_tlp_end} <= 2'h3;
      receive_data <= {e[26:19], 14'h0, 10'h005, 16'hBEEF, 8'h2A, e[18:11]};
      receive_bar_hit <= e[10:4];
      unsupported_request_flag <= e[26:19] inside {`FT_MRDLK32, `FT_MRDLK64, `FT_CPLLK,
                                                   `FT_CPLDLK};
      @(posedge clk);
      {receive_tlp_start, receive_tlp_end, unsupported_request_flag} <= 3'h0;
      // Released lines show the inverse so a stale value is never mistaken for data.
      receive_data <= ~receive_data;
      receive_bar_hit <= ~receive_bar_hit;
   endtask
endmodule

// ==== test/ur_host_bench.sv ====
// Bench of the unsupported-request host.
`timescale 1ns/1ps
`include "ur_host_defines.svh"
module ur_host_bench;
   logic clk = '0, nrst = '0, wb_cyc_i = '0, wb_stb_i = '0, wb_we_i = '0, cpl_req_ready = '0;
   logic receive_ecrc_error = '0, receive_malformed = '0, msi_enable_in = '1, app_got = '0;
   logic [3:0] wb_sel_i = '1, seen = '0, aer = '0, command_bits_in;
   logic [7:0] wb_adr_i = '0, msi_request, posted_data_count, pdn, irq = '0;
   logic [31:0] wb_dat_i = '0, wb_dat_o, rd, lk = 32'hC3A55A3C;
   logic [10:0] st = 11'h5AB;
   logic wb_ack_o, cpl_req_valid, receive_tlp_start, receive_tlp_end, unsupported_request_flag;
   logic pme_status_in, pme_enable_in, nonposted_header_done, posted_header_done;
   logic posted_data_done, completion_timeout_out, completer_abort_nonposted_in;
   logic completer_abort_posted, unexpected_completion, app_tlp_valid;
   logic [63:0] receive_data, app_tlp_header;
   logic [6:0] receive_bar_hit;
   logic [2:0] multi_message_enable_out;
   logic [1:0] power_state_out;
   logic [15:0] device_control_in, link_control_in;
   logic [127:0] errored_tlp_header;
   ur_host_pkg::cpl_req_t cpl_req;
   int n_errors = 0, cmp_count = 0, cyc = 0;
   // Expectation nibble: {completion taken, nonposted, posted header, posted data}.
   logic [26:0] tab [12] = '{
      {`FT_MRDLK32, 8'h0, 7'h2, 4'hC},
      {`FT_CPLLK, 8'h0, 7'h0, 4'h0},
      {8'h30, 8'h7E, 7'h0, 4'hA}, {8'h70, 8'h7F, 7'h0, 4'hB},
      {`FT_MRD32, 8'h0, 7'h0, 4'hC}, {`FT_MRD32, 8'h0, 7'h1, 4'hC},
      {`FT_IORD, 8'h0, 7'h2, 4'hC}, {`FT_IOWR, 8'h0, 7'h2, 4'hC},
      {`FT_MWR32, 8'h0, 7'h1, 4'h3},
      {8'h30, 8'h0, 7'h0, 4'h2}, {8'h70, 8'h0, 7'h0, 4'h3},
      {`FT_CFGRD0, 8'h0, 7'h0, 4'h4}};
   assign {pme_enable_in, pme_status_in, command_bits_in, power_state_out,
           multi_message_enable_out} = st;
   assign {link_control_in, device_control_in} = lk;
   ur_host dut (.*);
   device_model dev (.*);
   always #10 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) end_sim(1'h1);
      seen <= seen | {cpl_req_valid & cpl_req_ready, nonposted_header_done,
                      posted_header_done, posted_data_done};
      if (posted_data_done) pdn <= posted_data_count;
      irq <= irq | msi_request;
      app_got <= app_got | app_tlp_valid;
      aer <= aer | {unexpected_completion, completer_abort_posted,
                    completer_abort_nonposted_in, completion_timeout_out};
   end
   task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      @(posedge clk);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, we, adr, dat};
      do @(posedge clk); while (wb_ack_o !== 1'h1);
      rd = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'h0;
   endtask
   // Completion is stalled a few cycles before it is accepted.
   task automatic tlp(input logic [26:0] e);
      @(negedge clk) {seen, app_got} = 5'h00;
      dev.send(e);
      repeat (4) @(negedge clk);
      check("cpl valid", cpl_req_valid, e[3]);
      if (e[3]) check("cpl", cpl_req, {`CPL_UR, 16'hBEEF, 8'h2A});
      @(posedge clk) cpl_req_ready <= 1'h1;
      repeat (2) @(posedge clk);
      cpl_req_ready <= 1'h0;
      @(negedge clk) check("credits", seen, e[3:0]);
      if (e[0]) check("data credits", pdn, 8'h2);
      check("to user", app_got, e[26:19] == `FT_CFGRD0);
   endtask
   task automatic end_sim(input logic hang);
      n_errors += hang;
      if (n_errors == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge clk);
      nrst <= 1'h1;
      wb(1'h0, `OFS_CTRL, 32'h0);
      check("ctrl", rd, 32'h1);
      wb(1'h0, 8'h3C, 32'h0);
      check("unmapped", rd, 32'h0);
      tlp({`FT_CFGWR0, 8'h0, 7'h0, 4'h0});
      wb(1'h1, `OFS_CTRL, 32'hE);
      // A malformed write is dropped with no credit, completion or forwarding.
      receive_malformed <= 1'h1;
      tlp({`FT_MWR32, 8'h0, 7'h2, 4'h0});
      receive_malformed <= 1'h0;
      foreach (tab[i]) tlp(tab[i]);
      wb(1'h1, `OFS_MSI_ISSUE, 32'h81);
      msi_enable_in <= 1'h0;
      wb(1'h1, `OFS_MSI_ISSUE, 32'h7E);
      wb(1'h1, `OFS_AER_REPORT, 32'hF);
      wb(1'h0, `OFS_STATUS, 32'h0);
      check("status", rd, {20'h0, st, 1'h0});
      check("interrupts", irq, 8'h81);
      check("error reports", aer, 4'hF);
      wb(1'h0, `OFS_LINK, 32'h0);
      check("link", rd, lk);
      wb(1'h0, `OFS_UR_COUNT, 32'h0);
      check("counts", rd, 32'h00020007);
      wb(1'h0, `OFS_DROP_COUNT, 32'h0);
      check("drops", rd, 32'h00000001);
      check("error header", errored_tlp_header[127:96], 32'h04000005);
      end_sim(1'h0);
   end
endmodule
